//--- shared/scss_pkg.sv
// Shared constants and types of the system clock source select block
`default_nettype none
package scss_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] SYS_CTRL_ADDR  = 4'h0; // system_control_word
  localparam logic [3:0] LOOP_CTRL_ADDR = 4'h4; // loop_control_word
  localparam logic [3:0] PRESC_ADDR     = 4'h8; // prescaler word
  localparam logic [3:0] STATUS_ADDR    = 4'hC; // status, read only
  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int SEL_LSB    = 0;  // Source select, 2 bits
  localparam int BYPASS_BIT = 0;  // oscillator_path_bypass
  localparam int REFSEL_BIT = 1;  // 0 crystal, 1 internal source
  localparam int BAND_LSB   = 2;  // oscillator_band_select, 2 bits
  localparam int LOOP_INPUT_DIVIDE_FIELD_LSB   = 4;  // loop_input_divide_field
  localparam int LOOP_FEEDBACK_MULTIPLY_FIELD_LSB   = 8;  // loop_feedback_multiply_field
  localparam int K2_LSB     = 16; // loop_output_divide_field
  localparam int LOOP_INPUT_DIVIDE_FIELD_W     = 4;
  localparam int LOOP_FEEDBACK_MULTIPLY_FIELD_W     = 7;
  localparam int K2_W       = 7;
  localparam int K1_W       = 10; // Largest factor 1024
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]  SEL_RST   = 2'h0;        // Wakeup source
  localparam logic [31:0] LOOP_RST  = 32'h0000_0001; // Bypass set
  localparam logic [9:0]  PRESC_RST = 10'h000;
  // ----------------------------------------------------------------
  // Source select codes and clock paths
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_WAKE   = 2'h0;
  localparam logic [1:0] SEL_OSC    = 2'h2;
  localparam logic [1:0] SEL_DIRECT = 2'h3;
  localparam logic [1:0] PATH_WAKE   = 2'h0;
  localparam logic [1:0] PATH_LOOP   = 2'h1;
  localparam logic [1:0] PATH_PRESC  = 2'h2;
  localparam logic [1:0] PATH_DIRECT = 2'h3;
  localparam logic [1:0] BAND_LOW    = 2'h0;  // 50 to 110 MHz band
  localparam logic [1:0] BAND_HIGH   = 2'h1;  // 100 to 160 MHz band
  // Source switch states
  typedef enum logic {SW_RUN, SW_PARK} scss_sw_e;
  // Division factor is the field value plus one
  function automatic logic [10:0] factor(input logic [9:0] field);
    factor = {1'b0, field} + 11'h001;
  endfunction : factor
endpackage : scss_pkg
`default_nettype wire

//--- core/scss_divider.sv
// Integer clock divider working on source edge ticks
`timescale 1ns/100ps
`default_nettype none
module scss_divider #(
  parameter int W = 10
) (
  // Clock and reset
  input  wire logic         sys_clk_in,
  input  wire logic         reset_in,
  // Source clock as level and rising edge tick
  input  wire logic         level_in,
  input  wire logic         tick_in,
  // Division field, factor is field plus one
  input  wire logic [W-1:0] field_in,
  // Divided clock level
  output logic              div_level_out
);
  logic [W-1:0] count_q;   // Source edges seen in this period
  logic [10:0]  k_w;       // Division factor
  logic [10:0]  high_w;    // Edges spent high, half rounded up
  logic         wrap_w;    // Last edge of the period
  logic         level_d;

  assign k_w    = scss_pkg::factor(10'(field_in));
  assign high_w = 11'((k_w + 11'h001) >> 1);
  assign wrap_w = (count_q == field_in);
  // Factor one passes the source level straight on
  assign level_d = (field_in == '0) ? level_in :
                   (11'(count_q) < high_w);

  // Edge counter and output level
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      count_q       <= '0;
      div_level_out <= 1'b0;
    end else begin
      if (tick_in) begin
        count_q <= wrap_w ? '0 : count_q + 1'b1;
      end
      div_level_out <= level_d;
    end
  end

  // Factor one copies the source level one cycle later
  chk_div_bypass: assert property (@(posedge sys_clk_in)
    disable iff (reset_in)
    (field_in == '0) |=> (div_level_out == $past(level_in)))
    else $error("divider does not pass source through");
  // A period wraps after exactly factor source edges
  chk_div_wrap: assert property (@(posedge sys_clk_in)
    disable iff (reset_in)
    (tick_in && wrap_w) |=> (count_q == '0))
    else $error("divider period is wrong");
endmodule : scss_divider
`default_nettype wire

//--- core/scss_loop.sv
// Digital model of the frequency multiplying loop
`timescale 1ns/100ps
`default_nettype none
module scss_loop (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        reset_in,
  // Loop enable and reference edge tick
  input  wire logic        enable_in,
  input  wire logic        ref_tick_in,
  // Input divide and feedback multiply fields
  input  wire logic [3:0]  p_field_in,
  input  wire logic [6:0]  n_field_in,
  // Oscillator tick and lock flag
  output logic             vco_tick_out,
  output logic             locked_out
);
  logic [15:0] cnt_q;     // Cycles since last reference edge
  logic [15:0] period_q;  // Measured reference period
  logic [23:0] acc_q;     // Phase accumulator
  logic [23:0] thresh_w;  // P times reference period
  logic [23:0] sum_w;
  logic [10:0] p_w;
  logic [10:0] n_w;
  logic        fire_w;

  assign p_w      = scss_pkg::factor(10'(p_field_in));
  assign n_w      = scss_pkg::factor(10'(n_field_in));
  // Tick rate is N over P reference periods
  assign thresh_w = 24'(period_q) * 24'(p_w[4:0]);
  assign sum_w    = acc_q + 24'(n_w);
  assign fire_w   = enable_in && (thresh_w != '0) && (sum_w >= thresh_w);

  // Period measurement and accumulator
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cnt_q        <= '0;
      period_q     <= '0;
      acc_q        <= '0;
      vco_tick_out <= 1'b0;
      locked_out   <= 1'b0;
    end else if (!enable_in) begin
      cnt_q        <= '0;
      period_q     <= '0;
      acc_q        <= '0;
      vco_tick_out <= 1'b0;
      locked_out   <= 1'b0;
    end else begin
      cnt_q <= ref_tick_in ? '0 : (cnt_q + {15'h0000, ~&cnt_q});
      if (ref_tick_in) begin
        period_q   <= cnt_q + 16'h0001;
        // Locked while the measured period is steady
        locked_out <= (period_q == cnt_q + 16'h0001);
      end
      acc_q        <= fire_w ? sum_w - thresh_w : sum_w;
      vco_tick_out <= fire_w;
    end
  end

  // No oscillator ticks while the loop is off
  chk_loop_off: assert property (@(posedge sys_clk_in)
    disable iff (reset_in)
    !enable_in |=> !vco_tick_out)
    else $error("loop ticks while disabled");
endmodule : scss_loop
`default_nettype wire

//--- core/scss_top.sv
// System clock source select block with Avalon-MM register slave
//
// Function
// - Select 11 follows direct clock input exactly
// - Select 10, bypass 1 uses prescaled oscillator
// - Prescaler factor is field plus one
// - Largest prescaler factor divides by 1024
// - Factor one passes oscillator level through
// - Select 10, bypass 0 runs the loop
// - Loop multiplies by N over P times K2
// - Loop reference is crystal or internal source
// - System clock is oscillator divided by K2
// - Band select picks low or high band
// - Select 00 runs from wakeup source
`timescale 1ns/100ps
`default_nettype none
module scss_top (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        reset_in,
  // Avalon-MM register slave
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  // Clock source pins, asynchronous
  input  wire logic        direct_clock_input_in,
  input  wire logic        crystal_input_pin_in,
  input  wire logic        internal_clock_in,
  input  wire logic        wakeup_clock_in,
  // Derived system clock
  output logic             system_clock_out,
  output logic             system_clock_tick_out,
  // Loop control towards the analog oscillator
  output logic             loop_enable_out,
  output logic [1:0]       oscillator_band_out
);
  // ----------------------------------------------------------------
  // Source synchronisers
  // ----------------------------------------------------------------
  logic [3:0] src_meta_q;  // First stage, read only by second stage
  logic [3:0] src_sync_q;  // Synchronised source levels
  logic [3:0] src_prev_q;  // Previous level for edge detection
  logic [3:0] src_raw_w;
  logic [3:0] src_rise_w;  // One-cycle rising edge ticks

  // Order: direct, crystal, internal, wakeup
  assign src_raw_w  = {wakeup_clock_in, internal_clock_in,
                       crystal_input_pin_in, direct_clock_input_in};
  assign src_rise_w = src_sync_q & ~src_prev_q;

  // Two flip-flops on every pin before use
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      src_meta_q <= 4'h0;
      src_sync_q <= 4'h0;
      src_prev_q <= 4'h0;
    end else begin
      src_meta_q <= src_raw_w;
      src_sync_q <= src_meta_q;
      src_prev_q <= src_sync_q;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [1:0]  sel_q;       // system_clock_source_select
  logic [31:0] loop_q;      // loop_control_word
  logic [9:0]  presc_q;     // prescaler_divide_field
  logic        wait_q;      // Registered waitrequest
  logic [31:0] rdata_q;     // Registered read data

  // Field views of the loop control word
  logic              bypass_w;
  logic              refsel_w;
  logic [1:0]        band_w;
  logic [3:0]        loop_input_divide_field_w;
  logic [6:0]        loop_feedback_multiply_field_w;
  logic [6:0]        loop_output_divide_field_w;
  assign bypass_w = loop_q[scss_pkg::BYPASS_BIT];
  assign refsel_w = loop_q[scss_pkg::REFSEL_BIT];
  assign band_w   = loop_q[scss_pkg::BAND_LSB +: 2];
  assign loop_input_divide_field_w   = loop_q[scss_pkg::LOOP_INPUT_DIVIDE_FIELD_LSB +: scss_pkg::LOOP_INPUT_DIVIDE_FIELD_W];
  assign loop_feedback_multiply_field_w   = loop_q[scss_pkg::LOOP_FEEDBACK_MULTIPLY_FIELD_LSB +: scss_pkg::LOOP_FEEDBACK_MULTIPLY_FIELD_W];
  assign loop_output_divide_field_w  = loop_q[scss_pkg::K2_LSB +: scss_pkg::K2_W];

  // Bus decode: a request is taken when waitrequest is low
  logic        take_w;
  logic        wr_take_w;
  logic [31:0] loop_wmask_w;
  logic [31:0] rd_mux_w;
  logic [31:0] status_w;
  assign take_w    = (avs_read_in || avs_write_in) && !wait_q;
  assign wr_take_w = take_w && avs_write_in;
  // Only defined loop word fields are writable
  assign loop_wmask_w = 32'h007F_7FFF;

  // ----------------------------------------------------------------
  // Register writes and bus handshake
  // ----------------------------------------------------------------
  // Waitrequest drops for one cycle after a request appears
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !((avs_read_in || avs_write_in) && wait_q);
    end
  end

  // Writes land only at the accepting edge
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sel_q   <= scss_pkg::SEL_RST;
      loop_q  <= scss_pkg::LOOP_RST;
      presc_q <= scss_pkg::PRESC_RST;
    end else if (wr_take_w) begin
      unique case (avs_address_in)
        scss_pkg::SYS_CTRL_ADDR: begin
          sel_q <= avs_writedata_in[scss_pkg::SEL_LSB +: 2];
        end
        scss_pkg::LOOP_CTRL_ADDR: begin
          loop_q <= avs_writedata_in & loop_wmask_w;
        end
        scss_pkg::PRESC_ADDR: begin
          presc_q <= avs_writedata_in[scss_pkg::K1_W-1:0];
        end
        // Status and unmapped addresses ignore writes
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Clock paths
  // ----------------------------------------------------------------
  logic ref_level_w;    // Oscillator reference level
  logic ref_tick_w;     // Oscillator reference edge
  logic presc_level_w;  // Prescaler output
  logic vco_tick_w;     // Loop oscillator tick
  logic loop_level_w;   // Loop output after K2
  logic loop_locked_w;
  logic loop_on_w;

  // Reference is crystal or internal source
  assign ref_level_w = refsel_w ? src_sync_q[2] : src_sync_q[1];
  assign ref_tick_w  = refsel_w ? src_rise_w[2] : src_rise_w[1];
  // Loop runs only when selected with bypass clear
  assign loop_on_w = (sel_q == scss_pkg::SEL_OSC) && !bypass_w;

  // Prescaler on the oscillator reference
  scss_divider #(.W(scss_pkg::K1_W)) u_prescaler (
    .sys_clk_in    (sys_clk_in),
    .reset_in      (reset_in),
    .level_in      (ref_level_w),
    .tick_in       (ref_tick_w),
    .field_in      (presc_q),
    .div_level_out (presc_level_w)
  );

  // Multiplying loop
  scss_loop u_loop (
    .sys_clk_in   (sys_clk_in),
    .reset_in     (reset_in),
    .enable_in    (loop_on_w),
    .ref_tick_in  (ref_tick_w),
    .p_field_in   (loop_input_divide_field_w),
    .n_field_in   (loop_feedback_multiply_field_w),
    .vco_tick_out (vco_tick_w),
    .locked_out   (loop_locked_w)
  );

  // Output divider: one system period spans K2 oscillator ticks
  scss_divider #(.W(scss_pkg::K2_W)) u_out_div (
    .sys_clk_in    (sys_clk_in),
    .reset_in      (reset_in),
    .level_in      (vco_tick_w),
    .tick_in       (vco_tick_w),
    .field_in      (loop_output_divide_field_w),
    .div_level_out (loop_level_w)
  );

  // ----------------------------------------------------------------
  // Source switch
  // ----------------------------------------------------------------
  logic [3:0]          path_level_w;  // Level of each clock path
  logic [1:0]          target_w;      // Path wanted by software
  logic [1:0]          active_q;      // Path now driving the clock
  scss_pkg::scss_sw_e  sw_q;
  scss_pkg::scss_sw_e  sw_d;
  logic [1:0]          active_d;
  logic                clk_d;

  assign path_level_w[scss_pkg::PATH_WAKE]   = src_sync_q[3];
  assign path_level_w[scss_pkg::PATH_LOOP]   = loop_level_w;
  assign path_level_w[scss_pkg::PATH_PRESC]  = presc_level_w;
  assign path_level_w[scss_pkg::PATH_DIRECT] = src_sync_q[0];

  // Code 01 is reserved and falls back to the wakeup path
  assign target_w =
    (sel_q == scss_pkg::SEL_DIRECT) ? scss_pkg::PATH_DIRECT :
    (sel_q != scss_pkg::SEL_OSC)    ? scss_pkg::PATH_WAKE :
    bypass_w ? scss_pkg::PATH_PRESC : scss_pkg::PATH_LOOP;

  // Leave a path only when it is low, join the next when it is low
  always_comb begin
    sw_d     = sw_q;
    active_d = active_q;
    clk_d    = 1'b0;
    unique case (sw_q)
      scss_pkg::SW_RUN: begin
        clk_d = path_level_w[active_q];
        if (target_w != active_q && !path_level_w[active_q]) begin
          sw_d  = scss_pkg::SW_PARK;
          clk_d = 1'b0;
        end
      end
      scss_pkg::SW_PARK: begin
        if (!path_level_w[target_w]) begin
          sw_d     = scss_pkg::SW_RUN;
          active_d = target_w;
        end
      end
    endcase
  end

  // Switch state and registered clock outputs
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sw_q                  <= scss_pkg::SW_RUN;
      active_q              <= scss_pkg::PATH_WAKE;
      system_clock_out      <= 1'b0;
      system_clock_tick_out <= 1'b0;
    end else begin
      sw_q                  <= sw_d;
      active_q              <= active_d;
      system_clock_out      <= clk_d;
      system_clock_tick_out <= clk_d && !system_clock_out;
    end
  end

  // Loop control outputs
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      loop_enable_out     <= 1'b0;
      oscillator_band_out <= scss_pkg::BAND_LOW;
    end else begin
      loop_enable_out     <= loop_on_w;
      oscillator_band_out <= band_w;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  assign status_w = {27'h000_0000,
                     system_clock_out, loop_locked_w,
                     (sw_q == scss_pkg::SW_PARK), active_q};
  assign rd_mux_w =
    (avs_address_in == scss_pkg::SYS_CTRL_ADDR)  ? {30'h0, sel_q} :
    (avs_address_in == scss_pkg::LOOP_CTRL_ADDR) ? loop_q :
    (avs_address_in == scss_pkg::PRESC_ADDR)     ? {22'h0, presc_q} :
    (avs_address_in == scss_pkg::STATUS_ADDR)    ? status_w :
    32'h0000_0000;

  // Read data is loaded when waitrequest is about to drop
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read_in && wait_q) begin
      rdata_q <= rd_mux_w;
    end
  end
  assign avs_readdata_out    = rdata_q;
  assign avs_waitrequest_out = wait_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Direct path copies the synchronised direct level one cycle later
  chk_direct_follow: assert property (@(posedge sys_clk_in)
    disable iff (reset_in)
    (sw_q == scss_pkg::SW_RUN && sw_d == scss_pkg::SW_RUN &&
     active_q == scss_pkg::PATH_DIRECT)
    |=> (system_clock_out == $past(src_sync_q[0])))
    else $error("direct clock not followed");
  // Wakeup path copies the wakeup level one cycle later
  chk_wake_follow: assert property (@(posedge sys_clk_in)
    disable iff (reset_in)
    (sw_q == scss_pkg::SW_RUN && sw_d == scss_pkg::SW_RUN &&
     active_q == scss_pkg::PATH_WAKE)
    |=> (system_clock_out == $past(src_sync_q[3])))
    else $error("wakeup clock not followed");
  // No clock high while parked between sources
  chk_park_low: assert property (@(posedge sys_clk_in)
    disable iff (reset_in)
    (sw_q == scss_pkg::SW_PARK) |=> !system_clock_out ||
      ($past(sw_q) == scss_pkg::SW_PARK && sw_q == scss_pkg::SW_RUN))
    else $error("clock high while parked");
  // Clock low at every change of the active path
  chk_switch_low: assert property (@(posedge sys_clk_in)
    disable iff (reset_in)
    (active_q != $past(active_q)) |-> !$past(system_clock_out))
    else $error("source switched while clock high");
  // Loop enable tracks select 10 with bypass clear
  chk_loop_enable: assert property (@(posedge sys_clk_in)
    disable iff (reset_in)
    ##1 (loop_enable_out == $past(loop_on_w)))
    else $error("loop enable wrong");
  // Band output follows the band field
  chk_band_out: assert property (@(posedge sys_clk_in)
    disable iff (reset_in)
    ##1 (oscillator_band_out == $past(band_w)))
    else $error("band select not applied");
  // A request is answered one cycle after it appears
  chk_bus_answer: assert property (@(posedge sys_clk_in)
    disable iff (reset_in)
    ((avs_read_in || avs_write_in) && wait_q) |=> !wait_q ##1 wait_q)
    else $error("waitrequest timing wrong");
  // Prescaler path chosen when select 10 and bypass set
  chk_presc_path: assert property (@(posedge sys_clk_in)
    disable iff (reset_in)
    (sel_q == scss_pkg::SEL_OSC && bypass_w)
    |-> (target_w == scss_pkg::PATH_PRESC))
    else $error("prescaler path not targeted");
endmodule : scss_top
`default_nettype wire

//--- tb/scss_tb_top.sv
// Self-checking testbench of the system clock source select block
`timescale 1ns/100ps
`default_nettype none
module system_clock_source_select_tb_top;
  // ----------------------------------------------------------------
  // Stimulus and observation signals
  // ----------------------------------------------------------------
  logic        clk;       // 25 MHz system clock
  logic        rst;       // Active high reset
  logic [3:0]  addr;      // Bus address
  logic        rd;        // Read request
  logic        wr;        // Write request
  logic [31:0] wdata;     // Write data
  logic [31:0] rdata;     // Read data
  logic        wait_q;    // Wait request
  logic        sclk;      // Derived system clock
  logic        stick;     // Derived clock edge tick
  logic        lena;      // Loop enable
  logic [1:0]  band;      // Band output
  logic [15:0] cnt = 16'h0000; // Free cycle counter for the sources
  logic [31:0] rv;        // Last read value
  int          failures;  // Mismatch count
  int          compares;  // Comparison count
  int          hrun = 0;  // Current high run of the system clock
  // ----------------------------------------------------------------
  // Device under test
  // ----------------------------------------------------------------
  scss_top dut (
    .sys_clk_in(clk), .reset_in(rst),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wait_q),
    .direct_clock_input_in(cnt % 8 < 4), .crystal_input_pin_in(cnt % 6 < 3),
    .internal_clock_in(cnt % 10 < 5), .wakeup_clock_in(cnt % 24 < 12),
    .system_clock_out(sclk), .system_clock_tick_out(stick),
    .loop_enable_out(lena), .oscillator_band_out(band));
  // Clock generator
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Source clocks follow a counter updated on the rising edge
  always @(posedge clk) cnt <= cnt + 16'h0001;
  // Runt pulse monitor on the system clock
  always @(posedge clk) begin
    if (sclk === 1'b1) hrun++;
    else begin
      if (hrun == 1) begin
        failures++;
        $display("[ERR] %0t runt high pulse", $time);
      end
      hrun = 0;
    end
  end
  // Compare and count
  task automatic chk(input logic [31:0] got, exp, input string m);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // Bus cycle held until waitrequest is sampled low
  task automatic bus(input logic [3:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wr    <= w;
    rd    <= ~w;
    wdata <= d;
    do @(posedge clk); while (wait_q !== 1'b0);
    rv = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  // Read one word and compare it
  task automatic rchk(input logic [3:0] a, input logic [31:0] e,
                      input logic [31:0] m, input string s);
    bus(a, 1'b0, 32'h0000_0000);
    chk(rv & m, e, s);
  endtask : rchk
  // Measure one system clock period and its high time in cycles
  task automatic per(input int p, input int h, input string s);
    int n;
    int hi;
    n = 0;
    hi = 0;
    repeat (2) begin
      do @(posedge clk); while (stick !== 1'b1);
    end
    do begin
      @(posedge clk);
      n++;
      if (sclk === 1'b1) hi++;
    end while (stick !== 1'b1);
    chk(n, p, s);
    if (h > 0) chk(hi, h, s);
    $display("test done: %s", s);
  endtask : per
  // Print counts and verdict, then stop
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  // Watchdog against hangs
  initial begin
    #(40 * 80000);
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    report_and_stop();
  end
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1; addr = 4'h0; rd = 1'b0; wr = 1'b0;
    wdata = 32'h0000_0000;
    failures = 0; compares = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // Reset values and wakeup default
    rchk(4'h0, 32'h0000_0000, 32'hFFFF_FFFF, "sel reset");
    rchk(4'h4, 32'h0000_0001, 32'hFFFF_FFFF, "loop reset");
    rchk(4'h8, 32'h0000_0000, 32'hFFFF_FFFF, "presc reset");
    per(24, 12, "wakeup");
    rchk(4'hC, 32'h0000_0000, 32'h0000_0003, "wake path");
    // Read-only and unmapped places
    bus(4'hC, 1'b1, 32'hFFFF_FFFF);
    rchk(4'h0, 32'h0000_0000, 32'hFFFF_FFFF, "ro write");
    rchk(4'h1, 32'h0000_0000, 32'hFFFF_FFFF, "unmapped");
    // Direct drive keeps period and duty
    bus(4'h0, 1'b1, 32'h0000_0003);
    per(8, 4, "direct");
    rchk(4'hC, 32'h0000_0003, 32'h0000_0003, "direct path");
    // Prescaler: factor one, two, four, largest
    bus(4'h0, 1'b1, 32'h0000_0002);
    bus(4'h8, 1'b1, 32'h0000_0000);
    per(6, 3, "presc k1");
    rchk(4'hC, 32'h0000_0002, 32'h0000_0003, "presc path");
    bus(4'h8, 1'b1, 32'h0000_0001);
    per(12, 6, "presc k2");
    bus(4'h8, 1'b1, 32'h0000_0003);
    per(24, 12, "presc k4");
    bus(4'h8, 1'b1, 32'h0000_03FF);
    per(6144, 3072, "presc k1024");
    // Internal reference through the prescaler
    bus(4'h8, 1'b1, 32'h0000_0001);
    bus(4'h4, 1'b1, 32'h0000_0003);
    per(20, 10, "internal ref");
    // Loop: P 1, N 2, K2 3, high band, crystal reference
    bus(4'h4, 1'b1, 32'h0002_0104);
    rchk(4'h4, 32'h0002_0104, 32'hFFFF_FFFF, "loop word");
    chk({30'h0, lena, band[0]}, 32'h0000_0003, "loop en");
    chk({30'h0, band}, 32'h0000_0001, "band");
    repeat (300) @(posedge clk);
    per(9, 6, "loop rate");
    rchk(4'hC, 32'h0000_0009, 32'h0000_000B, "loop path");
    // Low band and return to wakeup through reserved code
    bus(4'h4, 1'b1, 32'h0002_0100);
    // Band output is registered one cycle after the write lands
    repeat (2) @(posedge clk);
    chk({30'h0, band}, 32'h0000_0000, "band low");
    bus(4'h0, 1'b1, 32'h0000_0001);
    per(24, 12, "wakeup again");
    chk({31'h0, lena}, 32'h0000_0000, "loop off");
    report_and_stop();
  end
endmodule : system_clock_source_select_tb_top
`default_nettype wire
